// ---- itfd_pkg.sv ----
// Constants, register map and function codes of the input terminal function decoder
package itfd_pkg;

  // Terminal count and function assignment width
  localparam int unsigned NUM_TERM   = 10;
  localparam int unsigned FN_W       = 6;
  localparam int unsigned TERM_W     = 4;

  // Pulse-capable inputs (fifth and sixth terminal)
  localparam logic [TERM_W-1:0] PULSE_CAPABLE_INPUT_A = 4'h4;
  localparam logic [TERM_W-1:0] PULSE_CAPABLE_INPUT_B = 4'h5;

  // Register byte offsets (word aligned)
  localparam logic [7:0] OFS_FN_BASE   = 8'h00;  // 0x00..0x24, one per terminal
  localparam logic [7:0] OFS_CONFIG    = 8'h28;
  localparam logic [7:0] OFS_FN_STATUS = 8'h2c;
  localparam logic [7:0] OFS_STATUS    = 8'h30;

  // Config register field positions
  localparam int unsigned CFG_CTRL_MODE_BIT   = 0;   // control_mode_setting 0 speed, 1 torque
  localparam int unsigned CFG_PID_DIR_BIT     = 1;   // pid_direction_setting
  localparam int unsigned CFG_GAIN_SRC_LSB    = 2;   // pid_gain_switch_source, 2 bits
  localparam int unsigned CFG_CMD_SRC_LSB     = 4;   // command source, 2 bits
  localparam int unsigned CFG_CMD_MODE_LSB    = 6;   // terminal_command_mode_setting, 2 bits
  localparam int unsigned CFG_FAULT_ACT_LSB   = 8;   // user_fault_action_setting, 2 bits
  localparam int unsigned CFG_RUNTIME_EN_BIT  = 10;  // running-time settings allow clearing
  localparam int unsigned CFG_W               = 11;
  localparam logic [CFG_W-1:0] CFG_RESET      = 11'h000;

  // Status register field positions
  localparam int unsigned ST_TERM_LSB   = 0;
  localparam int unsigned ST_FAULT_LSB  = 16;
  localparam int unsigned ST_MOTOR_LSB  = 24;

  // Reset values
  localparam logic [FN_W-1:0] FN_RESET  = 6'h00;
  localparam logic [31:0]     DAT_RESET = 32'h0000_0000;

  // Function codes handled here
  localparam logic [FN_W-1:0] FN_TORQUE_BLOCK  = 6'd29;
  localparam logic [FN_W-1:0] FN_PULSE_IN      = 6'd30;
  localparam logic [FN_W-1:0] FN_RESERVED      = 6'd31;
  localparam logic [FN_W-1:0] FN_DC_BRAKE_NOW  = 6'd32;
  localparam logic [FN_W-1:0] FN_EXT_FAULT_NC  = 6'd33;
  localparam logic [FN_W-1:0] FN_FREQ_LOCK     = 6'd34;
  localparam logic [FN_W-1:0] FN_PID_REVERSE   = 6'd35;
  localparam logic [FN_W-1:0] FN_PANEL_STOP    = 6'd36;
  localparam logic [FN_W-1:0] FN_TO_COMM       = 6'd37;
  localparam logic [FN_W-1:0] FN_PID_INT_HOLD  = 6'd38;
  localparam logic [FN_W-1:0] FN_MAIN_PRESET   = 6'd39;
  localparam logic [FN_W-1:0] FN_AUX_PRESET    = 6'd40;
  localparam logic [FN_W-1:0] FN_MOTOR_SEL_LO  = 6'd41;
  localparam logic [FN_W-1:0] FN_MOTOR_SEL_HI  = 6'd42;
  localparam logic [FN_W-1:0] FN_PID_GAIN_SW   = 6'd43;
  localparam logic [FN_W-1:0] FN_USER_FAULT_A  = 6'd44;
  localparam logic [FN_W-1:0] FN_USER_FAULT_B  = 6'd45;
  localparam logic [FN_W-1:0] FN_MODE_TOGGLE   = 6'd46;
  localparam logic [FN_W-1:0] FN_EMERG_STOP    = 6'd47;
  localparam logic [FN_W-1:0] FN_DECEL_STOP    = 6'd48;
  localparam logic [FN_W-1:0] FN_DECEL_DC      = 6'd49;
  localparam logic [FN_W-1:0] FN_RUNTIME_CLR   = 6'd50;
  localparam logic [FN_W-1:0] FN_LINE_SWITCH   = 6'd51;
  localparam int unsigned     FN_LO            = 29;
  localparam int unsigned     FN_HI            = 51;
  localparam int unsigned     FN_CNT           = FN_HI - FN_LO + 1;

  // Fault codes
  localparam logic [7:0] EXTERNAL_FAULT_CODE = 8'h0f;  // 15
  localparam logic [7:0] USER_FAULT_CODE_A   = 8'h1b;  // 27
  localparam logic [7:0] USER_FAULT_CODE_B   = 8'h1c;  // 28
  localparam logic [7:0] NO_FAULT_CODE       = 8'h00;

  // Deceleration time selection: fourth set
  localparam logic [1:0] DECEL_TIME_FOURTH = 2'h3;

  // Setting values
  localparam logic [1:0] GAIN_SRC_TERMINAL = 2'h1;

  // Command sources
  typedef enum logic [1:0] {
    ITFD_SRC_PANEL    = 2'b00,
    ITFD_SRC_TERMINAL = 2'b01,
    ITFD_SRC_COMM     = 2'b10
  } itfd_src_e;

  // Terminal command modes
  typedef enum logic [1:0] {
    ITFD_TWO_LINE_1   = 2'b00,
    ITFD_TWO_LINE_2   = 2'b01,
    ITFD_THREE_LINE_1 = 2'b10,
    ITFD_THREE_LINE_2 = 2'b11
  } itfd_mode_e;

endpackage : itfd_pkg

// ---- itfd_top.sv ----
// Input terminal function decoder with Wishbone register access
`timescale 1ns/1ns
// How it works
// - Function 29 on blocks torque control and forces speed mode.
// - Function 30 is accepted only on the two pulse-capable inputs.
// - Function 32 rising asks for DC braking at once, no deceleration.
// - Function 33 on reports external fault code fifteen and stops the drive.
// - Function 34 on locks out every output frequency modification.
// - Function 35 on inverts the configured PID direction.
// - Function 36 stops the drive only under operation-panel command source.
// - Function 37 on turns terminal command source into communication.
// - Function 38 on freezes PID integral; P and D keep running.
// - Functions 39 and 40 substitute preset frequency for main and auxiliary.
// - Functions 41 and 42 form a two-bit motor group code.
// - With gain source setting 1, function 43 picks gain set two when on.
// - Functions 44 and 45 raise user faults 27 and 28 with configured action.
// - Function 46 on selects the opposite of the configured control mode.
// - Function 47 on requests fastest stop at the current upper limit.
// - Function 48 decelerates to stop using deceleration time four, any source.
// - Function 49 rising decelerates to stop-brake frequency then DC brakes.
// - Function 50 rising clears running time when running-time settings allow.
// - Function 51 on turns two-line mode 1 into three-line mode 1.
// - Motor code: second terminal is high bit, OFF/OFF is motor 1.
module itfd_top
  import itfd_pkg::*;
(
  input  wire logic                     clk_i,              // System clock, 50 MHz
  input  wire logic                     rst_i,              // Synchronous reset, active high
  input  wire logic [31:0]              wb_adr_i,           // Wishbone byte address
  input  wire logic [31:0]              wb_dat_i,           // Wishbone write data
  input  wire logic [3:0]               wb_sel_i,           // Wishbone byte enables
  input  wire logic                     wb_we_i,            // Wishbone write enable
  input  wire logic                     wb_cyc_i,           // Wishbone cycle
  input  wire logic                     wb_stb_i,           // Wishbone strobe
  output logic [31:0]                   wb_dat_o,           // Wishbone read data
  output logic                          wb_ack_o,           // Wishbone acknowledge
  input  wire logic [itfd_pkg::NUM_TERM-1:0] term_i,        // Filtered terminal levels, 1 = ON
  output logic                          torque_mode_o,      // 1 = torque control, 0 = speed
  output logic                          pulse_input_o,      // Pulse input taken on a capable input
  output logic                          dc_brake_now_o,     // Pulse: DC brake immediately
  output logic                          fault_stop_o,       // Level: fault raised, stop drive
  output logic [7:0]                    fault_code_o,       // Active fault code, 0 none
  output logic [1:0]                    fault_action_o,     // Protection action for user faults
  output logic                          freq_lock_o,        // Ignore frequency modification
  output logic                          pid_reverse_o,      // Effective PID direction
  output logic                          panel_stop_o,       // Panel-equivalent stop
  output logic [1:0]                    cmd_src_o,          // Effective command source
  output logic                          pid_int_hold_o,     // Freeze PID integral
  output logic                          main_preset_o,      // Main source = preset frequency
  output logic                          aux_preset_o,       // Aux source = preset frequency
  output logic [1:0]                    motor_sel_o,        // Motor group, 0 = motor 1
  output logic                          pid_gain_second_o,  // Use second PID gain set
  output logic                          emerg_stop_o,       // Fastest stop at current limit
  output logic                          decel_stop_o,       // Decelerate to stop
  output logic [1:0]                    decel_time_sel_o,   // Deceleration time set in use
  output logic                          decel_dc_brake_o,   // Pulse: decel then DC brake
  output logic                          runtime_clear_o,    // Pulse: clear running time
  output logic [1:0]                    cmd_mode_o          // Effective terminal command mode
);

  // Assertions share one clock and reset
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // Terminal index of a register offset, or NUM_TERM when not a function register
  function automatic logic [TERM_W-1:0] fn_reg_index(input logic [7:0] ofs);
    logic [7:0] idx;
    idx = (ofs - OFS_FN_BASE) >> 2;
    if (ofs >= OFS_FN_BASE && idx < 8'(NUM_TERM)) begin
      fn_reg_index = idx[TERM_W-1:0];
    end else begin
      fn_reg_index = TERM_W'(NUM_TERM);
    end
  endfunction : fn_reg_index

  // Whether terminal t may carry assignment code
  function automatic logic fn_allowed(input logic [FN_W-1:0] code, input logic [TERM_W-1:0] t);
    fn_allowed = (code >= FN_W'(FN_LO)) && (code <= FN_W'(FN_HI)) && (code != FN_RESERVED) &&
                 ((code != FN_PULSE_IN) || (t == PULSE_CAPABLE_INPUT_A) || (t == PULSE_CAPABLE_INPUT_B));
  endfunction : fn_allowed

  logic [FN_W-1:0]    fn_q   [NUM_TERM];
  logic [FN_W-1:0]    fn_d   [NUM_TERM];
  logic [CFG_W-1:0]   cfg_q, cfg_d;
  logic [31:0]        rdat_q, rdat_d;
  logic               ack_q, ack_d;
  logic [FN_HI:FN_LO] on_q, on_d;
  logic [FN_HI:FN_LO] prev_q;

  logic [7:0]         ofs;
  logic [TERM_W-1:0]  widx;
  logic               req;

  // Bus decode
  assign ofs  = wb_adr_i[7:0];
  assign widx = fn_reg_index(ofs);
  assign req  = wb_cyc_i && wb_stb_i && !ack_q && (wb_adr_i[31:8] == 24'h000000);

  // Register writes and read mux; one wait state, then ack for one cycle
  always_comb begin
    cfg_d  = cfg_q;
    rdat_d = rdat_q;
    ack_d  = wb_cyc_i && wb_stb_i && !ack_q;
    for (int i = 0; i < NUM_TERM; i++) begin
      fn_d[i] = fn_q[i];
    end
    if (req && wb_we_i) begin
      if (widx != TERM_W'(NUM_TERM) && wb_sel_i[0]) begin
        fn_d[widx] = wb_dat_i[FN_W-1:0];
      end else if (ofs == OFS_CONFIG) begin
        if (wb_sel_i[0]) cfg_d[7:0] = wb_dat_i[7:0];
        if (wb_sel_i[1]) cfg_d[CFG_W-1:8] = wb_dat_i[CFG_W-1:8];
      end
    end
    if (req && !wb_we_i) begin
      rdat_d = DAT_RESET;
      if (widx != TERM_W'(NUM_TERM)) begin
        rdat_d[FN_W-1:0] = fn_q[widx];
      end else if (ofs == OFS_CONFIG) begin
        rdat_d[CFG_W-1:0] = cfg_q;
      end else if (ofs == OFS_FN_STATUS) begin
        rdat_d[FN_CNT-1:0] = on_q;
      end else if (ofs == OFS_STATUS) begin
        rdat_d[ST_TERM_LSB +: NUM_TERM] = term_i;
        rdat_d[ST_FAULT_LSB +: 8]       = fault_code_o;
        rdat_d[ST_MOTOR_LSB +: 2]       = motor_sel_o;
      end
    end
  end

  // Bus and register state; unmapped offsets read zero, reads above 0xff return the last read data, unmapped writes drop
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg_q  <= CFG_RESET;
      rdat_q <= DAT_RESET;
      ack_q  <= 1'b0;
      for (int i = 0; i < NUM_TERM; i++) begin
        fn_q[i] <= FN_RESET;
      end
    end else begin
      cfg_q  <= cfg_d;
      rdat_q <= rdat_d;
      ack_q  <= ack_d;
      for (int i = 0; i < NUM_TERM; i++) begin
        fn_q[i] <= fn_d[i];
      end
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;

  // Per-function ON levels; several terminals with one function are ORed
  always_comb begin
    on_d = '0;
    for (int t = 0; t < NUM_TERM; t++) begin
      if (term_i[t] && fn_allowed(fn_q[t], TERM_W'(t))) begin
        on_d[fn_q[t]] = 1'b1;
      end
    end
  end

  // Output next values; every output is a flop
  logic       torque_d, pulse_d, dcb_d, fstop_d, flock_d, pidrev_d, pstop_d;
  logic       ihold_d, mpre_d, apre_d, gain_d, estop_d, dstop_d, ddc_d, rclr_d;
  logic [7:0] fcode_d;
  logic [1:0] src_d, msel_d, mode_d, fact_d, dsel_d;
  logic [1:0] cfg_src, cfg_mode;

  assign cfg_src  = cfg_q[CFG_CMD_SRC_LSB +: 2];
  assign cfg_mode = cfg_q[CFG_CMD_MODE_LSB +: 2];

  always_comb begin
    // Blocking speed mode wins over the mode toggle
    torque_d = (cfg_q[CFG_CTRL_MODE_BIT] ^ on_q[FN_MODE_TOGGLE]) && !on_q[FN_TORQUE_BLOCK];
    pulse_d  = on_q[FN_PULSE_IN];
    dcb_d    = on_q[FN_DC_BRAKE_NOW] && !prev_q[FN_DC_BRAKE_NOW];
    // External fault outranks the two user faults
    if (on_q[FN_EXT_FAULT_NC]) begin
      fcode_d = EXTERNAL_FAULT_CODE;
    end else if (on_q[FN_USER_FAULT_A]) begin
      fcode_d = USER_FAULT_CODE_A;
    end else if (on_q[FN_USER_FAULT_B]) begin
      fcode_d = USER_FAULT_CODE_B;
    end else begin
      fcode_d = NO_FAULT_CODE;
    end
    fstop_d  = on_q[FN_EXT_FAULT_NC] || on_q[FN_USER_FAULT_A] || on_q[FN_USER_FAULT_B];
    flock_d  = on_q[FN_FREQ_LOCK];
    pidrev_d = cfg_q[CFG_PID_DIR_BIT] ^ on_q[FN_PID_REVERSE];
    pstop_d  = on_q[FN_PANEL_STOP] && (cfg_src == ITFD_SRC_PANEL);
    src_d    = (cfg_src == ITFD_SRC_TERMINAL && on_q[FN_TO_COMM]) ? ITFD_SRC_COMM : cfg_src;
    ihold_d  = on_q[FN_PID_INT_HOLD];
    mpre_d   = on_q[FN_MAIN_PRESET];
    apre_d   = on_q[FN_AUX_PRESET];
    msel_d   = {on_q[FN_MOTOR_SEL_HI], on_q[FN_MOTOR_SEL_LO]};
    gain_d   = (cfg_q[CFG_GAIN_SRC_LSB +: 2] == GAIN_SRC_TERMINAL) && on_q[FN_PID_GAIN_SW];
    estop_d  = on_q[FN_EMERG_STOP];
    dstop_d  = on_q[FN_DECEL_STOP];
    dsel_d   = dstop_d ? DECEL_TIME_FOURTH : 2'h0;
    fact_d   = cfg_q[CFG_FAULT_ACT_LSB +: 2];
    ddc_d    = on_q[FN_DECEL_DC] && !prev_q[FN_DECEL_DC];
    rclr_d   = on_q[FN_RUNTIME_CLR] && !prev_q[FN_RUNTIME_CLR] && cfg_q[CFG_RUNTIME_EN_BIT];
    mode_d   = (cfg_mode == ITFD_TWO_LINE_1 && on_q[FN_LINE_SWITCH]) ? ITFD_THREE_LINE_1 : cfg_mode;
  end

  // Decode pipeline: terminals to levels, then levels to requests
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      on_q              <= '0;
      prev_q            <= '0;
      torque_mode_o     <= 1'b0;
      pulse_input_o     <= 1'b0;
      dc_brake_now_o    <= 1'b0;
      fault_stop_o      <= 1'b0;
      fault_code_o      <= NO_FAULT_CODE;
      fault_action_o    <= 2'h0;
      freq_lock_o       <= 1'b0;
      pid_reverse_o     <= 1'b0;
      panel_stop_o      <= 1'b0;
      cmd_src_o         <= ITFD_SRC_PANEL;
      pid_int_hold_o    <= 1'b0;
      main_preset_o     <= 1'b0;
      aux_preset_o      <= 1'b0;
      motor_sel_o       <= 2'h0;
      pid_gain_second_o <= 1'b0;
      emerg_stop_o      <= 1'b0;
      decel_stop_o      <= 1'b0;
      decel_time_sel_o  <= 2'h0;
      decel_dc_brake_o  <= 1'b0;
      runtime_clear_o   <= 1'b0;
      cmd_mode_o        <= ITFD_TWO_LINE_1;
    end else begin
      on_q              <= on_d;
      prev_q            <= on_q;
      torque_mode_o     <= torque_d;
      pulse_input_o     <= pulse_d;
      dc_brake_now_o    <= dcb_d;
      fault_stop_o      <= fstop_d;
      fault_code_o      <= fcode_d;
      fault_action_o    <= fact_d;
      freq_lock_o       <= flock_d;
      pid_reverse_o     <= pidrev_d;
      panel_stop_o      <= pstop_d;
      cmd_src_o         <= src_d;
      pid_int_hold_o    <= ihold_d;
      main_preset_o     <= mpre_d;
      aux_preset_o      <= apre_d;
      motor_sel_o       <= msel_d;
      pid_gain_second_o <= gain_d;
      emerg_stop_o      <= estop_d;
      decel_stop_o      <= dstop_d;
      decel_time_sel_o  <= dsel_d;
      decel_dc_brake_o  <= ddc_d;
      runtime_clear_o   <= rclr_d;
      cmd_mode_o        <= mode_d;
    end
  end

  // Sequences for a terminal-level event reaching the outputs two edges later
  sequence fn_rise(int code);
    !on_q[code] ##1 on_q[code];
  endsequence

  speed_forced_a: assert property (on_q[FN_TORQUE_BLOCK] |=> !torque_mode_o)
    else $error("torque mode while blocked");
  pulse_only_ab_a: assert property (!(term_i[PULSE_CAPABLE_INPUT_A] || term_i[PULSE_CAPABLE_INPUT_B]) |=>
                                    !on_q[FN_PULSE_IN] ##1 !pulse_input_o)
    else $error("pulse input from a non capable terminal");
  dc_brake_pulse_a: assert property (fn_rise(FN_DC_BRAKE_NOW) |=> dc_brake_now_o ##1 !dc_brake_now_o)
    else $error("immediate DC brake pulse wrong");
  ext_fault_code_a: assert property (on_q[FN_EXT_FAULT_NC] |=> fault_code_o == EXTERNAL_FAULT_CODE
                                     && fault_stop_o)
    else $error("external fault not reported");
  freq_lock_follow_a: assert property (on_q[FN_FREQ_LOCK] |=> freq_lock_o)
    else $error("frequency lock missing");
  panel_stop_src_a: assert property (panel_stop_o |-> $past(cfg_src, 1) == ITFD_SRC_PANEL)
    else $error("panel stop outside panel source");
  comm_switch_a: assert property (on_q[FN_TO_COMM] && cfg_src == ITFD_SRC_TERMINAL |=>
                                  cmd_src_o == ITFD_SRC_COMM)
    else $error("command source not switched");
  motor_code_a: assert property (1'b1 |=> motor_sel_o == {$past(on_q[FN_MOTOR_SEL_HI]),
                                 $past(on_q[FN_MOTOR_SEL_LO])})
    else $error("motor select code wrong");
  decel_four_a: assert property (decel_stop_o |-> decel_time_sel_o == DECEL_TIME_FOURTH)
    else $error("deceleration time not fourth");
  runtime_gate_a: assert property (runtime_clear_o |-> $past(cfg_q[CFG_RUNTIME_EN_BIT]) ##1 !runtime_clear_o)
    else $error("running time clear not gated or not a pulse");
  line_switch_a: assert property (on_q[FN_LINE_SWITCH] && cfg_mode == ITFD_TWO_LINE_1 |=>
                                  cmd_mode_o == ITFD_THREE_LINE_1)
    else $error("line mode not switched");
  pid_dir_flip_a: assert property (1'b1 |=> pid_reverse_o == ($past(cfg_q[CFG_PID_DIR_BIT]) ^
                                   $past(on_q[FN_PID_REVERSE])))
    else $error("PID direction not inverted");
  int_hold_follow_a: assert property (on_q[FN_PID_INT_HOLD] |=> pid_int_hold_o)
    else $error("PID integral not held");
  preset_follow_a: assert property (on_q[FN_MAIN_PRESET] && on_q[FN_AUX_PRESET] |=>
                                    main_preset_o && aux_preset_o)
    else $error("preset substitution missing");
  gain_second_a: assert property (on_q[FN_PID_GAIN_SW] && cfg_q[CFG_GAIN_SRC_LSB +: 2] == GAIN_SRC_TERMINAL |=>
                                  pid_gain_second_o)
    else $error("second gain set not selected");
  user_fault_a: assert property (on_q[FN_USER_FAULT_A] && !on_q[FN_EXT_FAULT_NC] |=>
                                 fault_code_o == USER_FAULT_CODE_A && fault_stop_o)
    else $error("user fault not reported");
  mode_toggle_a: assert property (on_q[FN_MODE_TOGGLE] && !on_q[FN_TORQUE_BLOCK] |=>
                                  torque_mode_o != $past(cfg_q[CFG_CTRL_MODE_BIT]))
    else $error("control mode not toggled");
  emerg_follow_a: assert property (on_q[FN_EMERG_STOP] |=> emerg_stop_o)
    else $error("emergency stop missing");
  decel_dc_pulse_a: assert property (fn_rise(FN_DECEL_DC) |=> decel_dc_brake_o ##1 !decel_dc_brake_o)
    else $error("decel DC brake pulse wrong");
  bus_ack_once_a: assert property (wb_cyc_i && wb_stb_i && !ack_q |=> wb_ack_o ##1 !wb_ack_o)
    else $error("ack not a single cycle");

endmodule : itfd_top

// ---- itfd_switch_bank.sv ----
// Model of the switches and contacts wired to the input terminals
`timescale 1ns/1ns
module itfd_switch_bank (
  input  wire logic       clk_i,   // System clock
  input  wire logic [9:0] want_i,  // Contact positions asked by the bench
  output logic      [9:0] term_o   // Contact levels seen at the terminals
);
  logic [9:0] lvl_d;
  // Contacts move just after an edge; bounce is removed upstream by the filter
  always_comb begin
    lvl_d = want_i;
  end
  // Levels held until the bench moves a contact again
  always_ff @(posedge clk_i) begin
    term_o <= lvl_d;
  end
endmodule : itfd_switch_bank

// ---- tb_input_terminal_function_decoder.sv ----
// Self-checking bench for the input terminal function decoder
`timescale 1ns/1ns
module tb_input_terminal_function_decoder;
  import itfd_pkg::*;
  logic        clk_i = 1'b0, rst_i = 1'b1, wb_we_i = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0;
  logic [31:0] wb_adr_i = '0, wb_dat_i = '0, wb_dat_o, rd;
  logic [3:0]  wb_sel_i = '0;
  logic [9:0]  want = '0, term_i;
  logic        wb_ack_o, torque_mode_o, pulse_input_o, dc_brake_now_o, fault_stop_o, freq_lock_o;
  logic        pid_reverse_o, panel_stop_o, pid_int_hold_o, main_preset_o, aux_preset_o, pid_gain_second_o;
  logic        emerg_stop_o, decel_stop_o, decel_dc_brake_o, runtime_clear_o;
  logic [7:0]  fault_code_o;
  logic [1:0]  fault_action_o, cmd_src_o, motor_sel_o, decel_time_sel_o, cmd_mode_o;
  int          err_count = 0, n_compared = 0, pc_dc = 0, pc_ddc = 0, pc_rc = 0, s0, s1, s2;

  always #10 clk_i = ~clk_i;

  itfd_switch_bank itfd_switch_bank_inst (.clk_i(clk_i), .want_i(want), .term_o(term_i));
  itfd_top itfd_top_inst (
    .clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i),
    .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .term_i(term_i), .torque_mode_o(torque_mode_o), .pulse_input_o(pulse_input_o),
    .dc_brake_now_o(dc_brake_now_o), .fault_stop_o(fault_stop_o), .fault_code_o(fault_code_o),
    .fault_action_o(fault_action_o), .freq_lock_o(freq_lock_o), .pid_reverse_o(pid_reverse_o),
    .panel_stop_o(panel_stop_o), .cmd_src_o(cmd_src_o), .pid_int_hold_o(pid_int_hold_o),
    .main_preset_o(main_preset_o), .aux_preset_o(aux_preset_o), .motor_sel_o(motor_sel_o),
    .pid_gain_second_o(pid_gain_second_o), .emerg_stop_o(emerg_stop_o), .decel_stop_o(decel_stop_o),
    .decel_time_sel_o(decel_time_sel_o), .decel_dc_brake_o(decel_dc_brake_o),
    .runtime_clear_o(runtime_clear_o), .cmd_mode_o(cmd_mode_o));

  // Pulse counters; a pulse that stretches shows up as an extra count
  always @(posedge clk_i) begin
    if (dc_brake_now_o === 1'b1) pc_dc++;
    if (decel_dc_brake_o === 1'b1) pc_ddc++;
    if (runtime_clear_o === 1'b1) pc_rc++;
  end

  task automatic close_out;
    $display("Compared %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : close_out

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // Classic single cycle; request held until ack is sampled high at a rising edge
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat, input logic [3:0] sel);
    @(posedge clk_i);
    {wb_cyc_i, wb_stb_i, wb_we_i} <= {2'b11, we};
    wb_adr_i <= {24'h0, adr};
    wb_dat_i <= dat;
    wb_sel_i <= sel;
    do begin
      @(posedge clk_i);
    end while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'b000;
  endtask : wb

  task automatic fn(input int t, input logic [5:0] f);
    wb(1'b1, 8'(4 * t), {26'h0, f}, 4'h1);
  endtask : fn

  task automatic cfg(input logic [31:0] v);
    wb(1'b1, OFS_CONFIG, v, 4'h3);
  endtask : cfg

  // Move contacts, then wait out the model stage plus two decoder edges
  task automatic term(input logic [9:0] m);
    @(posedge clk_i);
    want <= m;
    repeat (4) @(posedge clk_i);
    @(negedge clk_i);
  endtask : term

  task automatic clr;
    term(10'h000);
    cfg(32'h0);
    for (int t = 0; t < 10; t++) fn(t, FN_RESET);
  endtask : clr

  task automatic t_levels;
    clr();
    fn(0, FN_FREQ_LOCK); fn(1, FN_PID_INT_HOLD); fn(2, FN_MAIN_PRESET);
    fn(3, FN_AUX_PRESET); fn(6, FN_EMERG_STOP); fn(7, FN_DECEL_STOP);
    term(10'h0cf);
    chk("freq_lock", freq_lock_o, 1);
    chk("int_hold", pid_int_hold_o, 1);
    chk("presets", {main_preset_o, aux_preset_o}, 2'b11);
    chk("emerg", emerg_stop_o, 1);
    chk("decel", {decel_stop_o, decel_time_sel_o}, {1'b1, DECEL_TIME_FOURTH});
    term(10'h000);
    chk("levels_off", {freq_lock_o, pid_int_hold_o, main_preset_o, emerg_stop_o, decel_stop_o}, 0);
  endtask : t_levels

  task automatic t_mode;
    clr();
    fn(0, FN_MODE_TOGGLE); fn(1, FN_TORQUE_BLOCK);
    cfg(32'h1);
    term(10'h000);
    chk("mode_kept", torque_mode_o, 1);
    term(10'h001);
    chk("mode_flip", torque_mode_o, 0);
    term(10'h002);
    chk("torque_block", torque_mode_o, 0);
    cfg(32'h0);
    term(10'h001);
    chk("mode_flip_sp", torque_mode_o, 1);
  endtask : t_mode

  // Two separate risings each give exactly one pulse
  task automatic t_pulse;
    clr();
    fn(0, FN_DC_BRAKE_NOW); fn(1, FN_DECEL_DC); fn(2, FN_RUNTIME_CLR);
    cfg(32'h400);
    {s0, s1, s2} = {pc_dc, pc_ddc, pc_rc};
    term(10'h007); term(10'h000); term(10'h007);
    chk("dc_now", pc_dc - s0, 2);
    chk("dec_dc", pc_ddc - s1, 2);
    chk("rt_clr", pc_rc - s2, 2);
    term(10'h000); cfg(32'h0); term(10'h004);
    chk("rt_off", pc_rc - s2, 2);
  endtask : t_pulse

  task automatic t_fault;
    logic [9:0] m[5] = '{10'h1, 10'h2, 10'h4, 10'h6, 10'h0};
    logic [7:0] e[5] = '{EXTERNAL_FAULT_CODE, USER_FAULT_CODE_A, USER_FAULT_CODE_B, USER_FAULT_CODE_A, 0};
    clr();
    fn(0, FN_EXT_FAULT_NC); fn(1, FN_USER_FAULT_A); fn(2, FN_USER_FAULT_B);
    cfg(32'h200);
    for (int i = 0; i < 5; i++) begin
      term(m[i]);
      chk("fault_code", fault_code_o, e[i]);
      chk("fault_stop", fault_stop_o, m[i] != 0);
    end
    chk("fault_act", fault_action_o, 2'h2);
  endtask : t_fault

  task automatic t_cmd;
    clr();
    fn(0, FN_PANEL_STOP); fn(1, FN_TO_COMM); fn(2, FN_LINE_SWITCH);
    term(10'h001);
    chk("panel_stop", panel_stop_o, 1);
    term(10'h002);
    chk("src_panel", cmd_src_o, ITFD_SRC_PANEL);
    term(10'h004);
    chk("three_line", cmd_mode_o, ITFD_THREE_LINE_1);
    cfg(32'h50);
    term(10'h001);
    chk("no_stop", panel_stop_o, 0);
    term(10'h006);
    chk("to_comm", cmd_src_o, ITFD_SRC_COMM);
    chk("mode_kept", cmd_mode_o, ITFD_TWO_LINE_2);
  endtask : t_cmd

  task automatic t_pid;
    clr();
    fn(0, FN_PID_REVERSE); fn(1, FN_PID_GAIN_SW);
    cfg(32'h2);
    term(10'h001);
    chk("pid_rev", pid_reverse_o, 0);
    term(10'h002);
    chk("pid_dir", pid_reverse_o, 1);
    chk("gain_nosrc", pid_gain_second_o, 0);
    cfg(32'h4);
    term(10'h002);
    chk("gain_two", pid_gain_second_o, 1);
    term(10'h000);
    chk("gain_one", pid_gain_second_o, 0);
  endtask : t_pid

  task automatic t_motor;
    clr();
    fn(3, FN_MOTOR_SEL_LO); fn(8, FN_MOTOR_SEL_HI);
    for (int i = 0; i < 4; i++) begin
      term({1'b0, i[1], 4'h0, i[0], 3'h0});
      chk("motor_sel", motor_sel_o, i[1:0]);
    end
  endtask : t_motor

  // Pulse function off the capable inputs and reserved codes request nothing
  task automatic t_misc;
    clr();
    fn(0, FN_PULSE_IN); fn(5, FN_PULSE_IN); fn(1, FN_RESERVED); fn(2, 6'h34);
    term(10'h007);
    chk("pulse_gen", pulse_input_o, 0);
    chk("reserved", {fault_stop_o, freq_lock_o, motor_sel_o, cmd_src_o}, 0);
    term(10'h020);
    chk("pulse_cap", pulse_input_o, 1);
    wb(1'b0, OFS_FN_STATUS, 32'h0, 4'hf);
    chk("fn_status", rd, 32'h1 << (30 - FN_LO));
    wb(1'b0, OFS_STATUS, 32'h0, 4'hf);
    chk("status", rd, 32'h20);
    wb(1'b0, 8'h14, 32'h0, 4'hf);
    chk("fn_rd", rd, 32'd30);
    wb(1'b0, 8'h40, 32'h0, 4'hf);
    chk("unmapped", rd, 32'h0);
  endtask : t_misc

  initial begin
    repeat (20000) @(posedge clk_i);
    err_count++;
    close_out();
  end

  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    @(negedge clk_i);
    chk("rst_out", {torque_mode_o, fault_code_o, cmd_src_o, cmd_mode_o}, 0);
    wb(1'b0, OFS_CONFIG, 32'h0, 4'hf);
    chk("cfg_rst", rd, 32'(CFG_RESET));
    t_levels(); t_mode(); t_pulse(); t_fault(); t_cmd(); t_pid(); t_motor(); t_misc();
    close_out();
  end
endmodule : tb_input_terminal_function_decoder
